// ===== design/sim_status_regs.sv
// Break status, reset status and break flag control registers of the
// system integration block, with an interrupt for break exits and logged resets.
// Assumes a single-cycle register port; reset is the power-on reset and the
// other reset sources arrive as one-cycle strobes while this block keeps running.
`timescale 1ns/1ps

module sim_status_regs
  import sim_regs_pkg::*;
(
  input  wire logic              clk_sys,                  // System clock, 125 MHz.
  input  wire logic              reset,                    // Power-on reset, async, active high.
  input  wire logic [ADDR_W-1:0] addr,                     // Register address.
  input  wire logic [DATA_W-1:0] wdata,                    // Write data.
  input  wire logic              wr,                       // Write strobe.
  input  wire logic              rd,                       // Read strobe.
  output logic      [DATA_W-1:0] rdata,                    // Read data, cycle after rd.
  input  wire logic              break_active,             // Processor is in the break state.
  input  wire logic              low_power_exit,           // Strobe: stop or wait mode was left.
  input  wire logic              exit_by_break,            // The exit was caused by a break interrupt.
  input  wire logic              pin_reset,                // Strobe: reset from the external pin.
  input  wire logic              watchdog_reset,           // Strobe: reset from the watchdog counter.
  input  wire logic              illegal_opcode_reset,     // Strobe: reset from an illegal opcode.
  input  wire logic              illegal_address_reset,    // Strobe: reset from an illegal address.
  input  wire logic              illegal_address_fetch,    // That access was an opcode fetch.
  input  wire logic              monitor_entry_reset,      // Strobe: reset from monitor mode entry.
  input  wire logic              reset_vector_blank,       // Reset vector locations read blank.
  input  wire logic              external_interrupt_pin,   // Interrupt pin sits at normal supply level.
  input  wire logic              low_voltage_reset,        // Strobe: reset from low-voltage inhibit.
  output logic                   break_stop_wait_flag,     // Copy of the break stop/wait flag.
  output logic                   break_clear_enable,       // Copy of the break clear enable bit.
  output logic                   irq                       // Level interrupt request.
);

  // Address decode and access strobes.

  logic hit_break;
  logic hit_reset;
  logic hit_control;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_state;

  assign hit_break      = (addr == ADDR_BREAK_STATUS);
  assign hit_reset      = (addr == ADDR_RESET_STATUS);
  assign hit_control    = (addr == ADDR_BREAK_FLAG_CONTROL);
  assign hit_irq_status = (addr == ADDR_IRQ_STATUS);
  assign hit_irq_mask   = (addr == ADDR_IRQ_MASK);
  assign hit_state      = (addr == ADDR_BLOCK_STATE);

  logic wr_break;
  logic wr_control;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic rd_reset;

  assign wr_break      = wr & hit_break;
  assign wr_control    = wr & hit_control;
  assign wr_irq_status = wr & hit_irq_status;
  assign wr_irq_mask   = wr & hit_irq_mask;
  assign rd_reset      = rd & hit_reset;

  // Protection of status flags while the processor sits in break.

  logic break_clear_enable_q;
  logic break_clear_enable_d;
  logic clear_allowed;

  // Software clears of break and reset status flags only act outside break or when enabled.
  // A clear refused here is simply dropped, so a flag cleared earlier in break
  // stays cleared and a protected flag clears on the next access after break.
  assign clear_allowed = ~break_active | break_clear_enable_q;

  assign break_clear_enable_d = wr_control ? wdata[BIT_BREAK_CLEAR_ENABLE]
                                           : break_clear_enable_q;

  // Reset cause logging.

  logic any_other_reset;
  logic illegal_address_set;
  logic monitor_entry_set;

  // Data accesses to an illegal address never mark the opcode-fetch cause.
  assign illegal_address_set = illegal_address_reset & illegal_address_fetch;

  // Monitor entry is only recorded for the blank-vector entry path with the interrupt pin at normal supply level.
  assign monitor_entry_set = monitor_entry_reset & reset_vector_blank
                           & external_interrupt_pin;

  assign any_other_reset = pin_reset | watchdog_reset | illegal_opcode_reset
                         | illegal_address_set | monitor_entry_set | low_voltage_reset;

  sticky_if #(.N(DATA_W)) cause_bus ();

  logic [DATA_W-1:0] cause_set;

  always_comb begin
    cause_set                      = '0;
    // Each source sets only its own bit; the others keep their value.
    cause_set[BIT_PIN_CAUSE]       = pin_reset;
    cause_set[BIT_WATCHDOG]        = watchdog_reset;
    cause_set[BIT_ILLEGAL_OPCODE]  = illegal_opcode_reset;
    cause_set[BIT_ILLEGAL_ADDRESS] = illegal_address_set;
    cause_set[BIT_MONITOR_ENTRY]   = monitor_entry_set;
    cause_set[BIT_LOW_VOLTAGE]     = low_voltage_reset;
  end

  assign cause_bus.set = cause_set;
  // A read clears all flags when clear_allowed; a source firing in that cycle still wins.
  assign cause_bus.clr = {DATA_W{rd_reset & clear_allowed}};

  // Power-on reset loads the power-on flag alone.
  cause_flags #(
    .N         (DATA_W),
    .RESET_VAL (RST_RESET_STATUS)
  ) u_cause_flags (
    .clk_sys (clk_sys),
    .reset   (reset),
    .flags   (cause_bus)
  );

  // Break stop/wait flag.

  logic break_stop_wait_q;
  logic break_stop_wait_d;
  logic break_exit_evt;
  logic break_flag_clear;

  assign break_exit_evt   = low_power_exit & exit_by_break;
  assign break_flag_clear = (wr_break & ~wdata[BIT_BREAK_STOP_WAIT] & clear_allowed)
                          | any_other_reset;

  // A break exit in the same cycle as a clear keeps the flag set.
  assign break_stop_wait_d = break_exit_evt | (break_stop_wait_q & ~break_flag_clear);

  // Interrupt status, mask and request.

  sticky_if #(.N(IRQ_W)) irq_bus ();

  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_mask;
  logic             irq_out;

  always_comb begin
    irq_set                     = '0;
    irq_set[IRQ_BIT_BREAK_EXIT] = break_exit_evt;
    irq_set[IRQ_BIT_RESET_LOG]  = any_other_reset;
  end

  assign irq_bus.set = irq_set;
  assign irq_bus.clr = wr_irq_status ? wdata[IRQ_W-1:0] : '0;

  irq_bank #(
    .N (IRQ_W)
  ) u_irq_bank (
    .clk_sys (clk_sys),
    .reset   (reset),
    .status  (irq_bus),
    .mask_we (wr_irq_mask),
    .mask_wd (wdata[IRQ_W-1:0]),
    .mask_q  (irq_mask),
    .irq_q   (irq_out)
  );

  // Read data selection.

  read_sel_t read_sel;

  assign read_sel = hit_break      ? SEL_BREAK       :
                    hit_reset      ? SEL_RESET       :
                    hit_control    ? SEL_CONTROL     :
                    hit_irq_status ? SEL_IRQ_STATUS  :
                    hit_irq_mask   ? SEL_IRQ_MASK    :
                    hit_state      ? SEL_BLOCK_STATE : SEL_NONE;

  logic [DATA_W-1:0] read_value;

  // Reserved bits and unmapped addresses read as zero.
  always_comb begin
    read_value = '0;
    case (read_sel)
      SEL_BREAK: begin
        read_value[BIT_BREAK_STOP_WAIT] = break_stop_wait_q;
      end
      SEL_RESET: begin
        read_value = cause_bus.q;
      end
      SEL_CONTROL: begin
        read_value[BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_q;
      end
      SEL_IRQ_STATUS: begin
        read_value[IRQ_W-1:0] = irq_bus.q;
      end
      SEL_IRQ_MASK: begin
        read_value[IRQ_W-1:0] = irq_mask;
      end
      SEL_BLOCK_STATE: begin
        read_value[BIT_STATE_BREAK_ACTIVE] = break_active;
        read_value[BIT_STATE_CLEAR_OK]     = clear_allowed;
      end
      default: begin
        read_value = '0;
      end
    endcase
  end

  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // Read data hold only for the cycle after the strobe, zero otherwise.
  assign rdata_d = rd ? read_value : '0;

  // State registers.

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      break_stop_wait_q    <= RST_BREAK_STATUS[BIT_BREAK_STOP_WAIT];
      break_clear_enable_q <= RST_BREAK_FLAG_CONTROL[BIT_BREAK_CLEAR_ENABLE];
      rdata_q              <= '0;
    end else begin
      break_stop_wait_q    <= break_stop_wait_d;
      break_clear_enable_q <= break_clear_enable_d;
      rdata_q              <= rdata_d;
    end
  end

  assign rdata                = rdata_q;
  assign break_stop_wait_flag = break_stop_wait_q;
  assign break_clear_enable   = break_clear_enable_q;
  assign irq                  = irq_out;

endmodule

// ===== design/sim_regs_pkg.sv
// Shared constants for the system integration status register bank.
// Assumes an 8-bit register port with 16-bit addresses in the processor memory map.
package sim_regs_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_BREAK_STATUS       = 16'hFE00;
  localparam logic [ADDR_W-1:0] ADDR_RESET_STATUS       = 16'hFE01;
  localparam logic [ADDR_W-1:0] ADDR_BREAK_FLAG_CONTROL = 16'hFE03;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS         = 16'hFE04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK           = 16'hFE05;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK_STATE        = 16'hFE06;

  // Break status field.
  localparam int BIT_BREAK_STOP_WAIT = 1;

  // Reset status fields.
  localparam int BIT_POWER_ON        = 7;
  localparam int BIT_PIN_CAUSE       = 6;
  localparam int BIT_WATCHDOG        = 5;
  localparam int BIT_ILLEGAL_OPCODE  = 4;
  localparam int BIT_ILLEGAL_ADDRESS = 3;
  localparam int BIT_MONITOR_ENTRY   = 2;
  localparam int BIT_LOW_VOLTAGE     = 1;

  // Break flag control field.
  localparam int BIT_BREAK_CLEAR_ENABLE = 7;

  // Interrupt status and mask fields.
  localparam int IRQ_W              = 2;
  localparam int IRQ_BIT_BREAK_EXIT = 0;
  localparam int IRQ_BIT_RESET_LOG  = 1;

  // Block state fields.
  localparam int BIT_STATE_BREAK_ACTIVE = 0;
  localparam int BIT_STATE_CLEAR_OK     = 1;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_BREAK_STATUS       = 8'h00;
  localparam logic [DATA_W-1:0] RST_RESET_STATUS       = 8'h80;
  localparam logic [DATA_W-1:0] RST_BREAK_FLAG_CONTROL = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ                = 2'h0;

  // Read-data source selection.
  typedef enum logic [2:0] {
    SEL_NONE        = 3'b000,
    SEL_BREAK       = 3'b001,
    SEL_RESET       = 3'b010,
    SEL_CONTROL     = 3'b011,
    SEL_IRQ_STATUS  = 3'b100,
    SEL_IRQ_MASK    = 3'b101,
    SEL_BLOCK_STATE = 3'b110
  } read_sel_t;

endpackage

// ===== design/sticky_if.sv
// Carrier between the register front end and its sticky flag banks.
// Assumes one clock domain; set and clear are single-cycle per-bit strobes.
`timescale 1ns/1ps
interface sticky_if #(
  parameter int N = 8
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;

  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface

// ===== design/cause_flags.sv
// Bank of sticky flags that hardware sets and software clears.
// Assumes set and clr are one-cycle strobes in the clk_sys domain.
`timescale 1ns/1ps
module cause_flags #(
  parameter int             N         = 8,
  parameter logic [N-1:0]   RESET_VAL = '0
) (
  input  wire logic clk_sys,   // System clock.
  input  wire logic reset,     // Asynchronous power-on reset.
  sticky_if.owner   flags      // Set, clear and state of the flags.
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      logic flag_q;
      logic flag_d;
      // A set in the same cycle as a clear wins, so no event is lost.
      assign flag_d = flags.set[i] | (flag_q & ~flags.clr[i]);
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          flag_q <= RESET_VAL[i];
        end else begin
          flag_q <= flag_d;
        end
      end
      assign flags.q[i] = flag_q;
    end
  endgenerate

endmodule

// ===== design/irq_bank.sv
// Interrupt status with write-one-to-clear bits, a mask and one level output.
// Assumes event strobes and clears are one cycle long in the clk_sys domain.
`timescale 1ns/1ps
module irq_bank
  import sim_regs_pkg::*;
#(
  parameter int N = IRQ_W
) (
  input  wire logic         clk_sys,   // System clock.
  input  wire logic         reset,     // Asynchronous power-on reset.
  sticky_if.owner           status,    // Events in, write-one clears in, status out.
  input  wire logic         mask_we,   // Mask write strobe.
  input  wire logic [N-1:0] mask_wd,   // Mask write data.
  output logic      [N-1:0] mask_q,    // Mask register.
  output logic              irq_q      // Level interrupt.
);

  logic [N-1:0] status_q;
  logic [N-1:0] status_d;
  logic         irq_d;

  assign status_d = status.set | (status_q & ~status.clr);
  assign irq_d    = |(status_d & (mask_we ? mask_wd : mask_q));
  assign status.q = status_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status_q <= N'(RST_IRQ);
      mask_q   <= N'(RST_IRQ);
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      if (mask_we) begin
        mask_q <= mask_wd;
      end
      irq_q    <= irq_d;
    end
  end

endmodule

// ===== sim/sim_status_regs_properties.sv
// Concurrent checks on the ports of the status register bank.
// Assumes one clk_sys domain and an asynchronous active-high reset.
`timescale 1ns/1ps
module sim_status_regs_properties
  import sim_regs_pkg::*;
(
  input wire logic              clk_sys,                // Clock.
  input wire logic              reset,                  // Reset.
  input wire logic [ADDR_W-1:0] addr,                   // Address.
  input wire logic [DATA_W-1:0] wdata,                  // Write data.
  input wire logic              wr,                     // Write strobe.
  input wire logic              rd,                     // Read strobe.
  input wire logic [DATA_W-1:0] rdata,                  // Read data.
  input wire logic              break_active,           // Break state.
  input wire logic              low_power_exit,         // Mode exit.
  input wire logic              exit_by_break,          // Exit cause.
  input wire logic              pin_reset,              // Pin cause.
  input wire logic              watchdog_reset,         // Watchdog cause.
  input wire logic              illegal_opcode_reset,   // Opcode cause.
  input wire logic              illegal_address_reset,  // Address cause.
  input wire logic              illegal_address_fetch,  // Fetch qualifier.
  input wire logic              monitor_entry_reset,    // Monitor cause.
  input wire logic              reset_vector_blank,     // Blank vector.
  input wire logic              external_interrupt_pin, // Pin level.
  input wire logic              low_voltage_reset,      // Low-voltage cause.
  input wire logic              break_stop_wait_flag,   // Flag copy.
  input wire logic              break_clear_enable,     // Enable copy.
  input wire logic              irq                     // Interrupt.
);
  wire hard_cause = pin_reset | watchdog_reset | illegal_opcode_reset | low_voltage_reset;
  wire any_cause  = hard_cause | illegal_address_reset | monitor_entry_reset;
  wire break_exit = low_power_exit & exit_by_break;
  wire clear_ok   = !break_active | break_clear_enable;
  wire enable_wd  = wdata[BIT_BREAK_CLEAR_ENABLE];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_rs_read;
    rd && addr == ADDR_RESET_STATUS;
  endsequence
  sequence s_clear_read;
    s_rs_read ##0 (clear_ok && !any_cause);
  endsequence

  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not zero");
  chk_unmapped_read: assert property (rd && addr == 16'hFE02 |=> rdata == 8'h00) else $error("unmapped read");
  chk_read_clears: assert property (s_clear_read ##1 !any_cause ##1 (s_rs_read ##0 !any_cause) |=> rdata == 8'h00)
    else $error("reset status not cleared by read");
  chk_pin_logged: assert property (pin_reset ##1 !rd ##1 s_rs_read |=> rdata[BIT_PIN_CAUSE])
    else $error("pin cause not logged");
  chk_watchdog_logged: assert property (watchdog_reset ##1 !rd ##1 s_rs_read |=> rdata[BIT_WATCHDOG])
    else $error("watchdog cause not logged");
  chk_stopwait_set: assert property (break_exit |=> break_stop_wait_flag) else $error("break exit flag not set");
  chk_stopwait_keep: assert property (!break_stop_wait_flag && !break_exit |=> !break_stop_wait_flag)
    else $error("break exit flag set without cause");
  chk_stopwait_clear: assert property (wr && addr == ADDR_BREAK_STATUS && !wdata[BIT_BREAK_STOP_WAIT] && clear_ok
    && !break_exit |=> !break_stop_wait_flag) else $error("break exit flag not cleared");
  chk_reset_clears: assert property (hard_cause && !break_exit |=> !break_stop_wait_flag)
    else $error("reset did not clear break exit flag");
  chk_stopwait_protect: assert property (break_active && !break_clear_enable && break_stop_wait_flag && !any_cause
    |=> break_stop_wait_flag) else $error("protected flag lost");
  chk_enable_write: assert property (wr && addr == ADDR_BREAK_FLAG_CONTROL |=> break_clear_enable == $past(enable_wd))
    else $error("break clear enable not written");
endmodule

bind sim_status_regs sim_status_regs_properties i_sim_status_regs_properties (.clk_sys(clk_sys), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .break_active(break_active),
  .low_power_exit(low_power_exit), .exit_by_break(exit_by_break), .pin_reset(pin_reset),
  .watchdog_reset(watchdog_reset), .illegal_opcode_reset(illegal_opcode_reset),
  .illegal_address_reset(illegal_address_reset), .illegal_address_fetch(illegal_address_fetch),
  .monitor_entry_reset(monitor_entry_reset), .reset_vector_blank(reset_vector_blank),
  .external_interrupt_pin(external_interrupt_pin), .low_voltage_reset(low_voltage_reset),
  .break_stop_wait_flag(break_stop_wait_flag), .break_clear_enable(break_clear_enable), .irq(irq));

// ===== sim/tb_top.sv
// Self-checking bench for the status register bank.
// Assumes the register port contract: one-cycle strobes, read data in the following cycle.
`timescale 1ns/1ps
module tb_top
  import sim_regs_pkg::*;
;
  typedef struct packed {logic [6:0] s; logic [3:0] l; logic [7:0] e;} row_t;
  logic              clk_sys, reset, wr, rd, brk, bsw, bce, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [6:0]        stb;
  logic [3:0]        lvl;
  int                err_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  row_t              rows [8];

  // Strobes: 0 mode exit, 1 pin, 2 watchdog, 3 opcode, 4 address, 5 monitor, 6 low voltage.
  sim_status_regs i_sim_status_regs (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .break_active(brk), .low_power_exit(stb[0]), .exit_by_break(lvl[0]),
    .pin_reset(stb[1]), .watchdog_reset(stb[2]), .illegal_opcode_reset(stb[3]), .illegal_address_reset(stb[4]),
    .illegal_address_fetch(lvl[1]), .monitor_entry_reset(stb[5]), .reset_vector_blank(lvl[2]),
    .external_interrupt_pin(lvl[3]), .low_voltage_reset(stb[6]), .break_stop_wait_flag(bsw),
    .break_clear_enable(bce), .irq(irq));

  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    check(nm, e, rdata);
  endtask

  // Strobes last one cycle; qualifier levels stay until the next pulse.
  task automatic pulse(input logic [6:0] s, input logic [3:0] l);
    @(posedge clk_sys);
    stb <= s;
    lvl <= l;
    @(posedge clk_sys);
    stb <= 7'h00;
    #1;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    reset = 1'b1; wr = 1'b0; rd = 1'b0; brk = 1'b0; addr = 16'h0000; wdata = 8'h00; stb = 7'h00; lvl = 4'h0;
    rows = '{'{7'h02, 4'h0, 8'h40}, '{7'h04, 4'h0, 8'h20}, '{7'h08, 4'h0, 8'h10}, '{7'h10, 4'h2, 8'h08},
             '{7'h10, 4'h0, 8'h00}, '{7'h20, 4'hC, 8'h04}, '{7'h20, 4'h8, 8'h00}, '{7'h40, 4'h0, 8'h02}};
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd_reg(ADDR_RESET_STATUS, 8'h80, "reset_status");
    rd_reg(ADDR_RESET_STATUS, 8'h00, "reset_status");
    rd_reg(ADDR_BREAK_STATUS, 8'h00, "break_status");
    rd_reg(ADDR_BREAK_FLAG_CONTROL, 8'h00, "break_flag_control");
    rd_reg(16'hFE02, 8'h00, "unmapped");
    foreach (rows[i]) begin
      pulse(rows[i].s, rows[i].l);
      rd_reg(ADDR_RESET_STATUS, rows[i].e, "reset_status row");
    end
    pulse(7'h02, 4'h0);
    pulse(7'h04, 4'h0);
    rd_reg(ADDR_RESET_STATUS, 8'h60, "reset_status pair");
    pulse(7'h01, 4'h0);
    check("break_stop_wait_flag", 8'h00, {7'h00, bsw});
    pulse(7'h01, 4'h1);
    rd_reg(ADDR_BREAK_STATUS, 8'h02, "break_status");
    wr_reg(ADDR_BREAK_STATUS, 8'h02);
    check("break_stop_wait_flag", 8'h01, {7'h00, bsw});
    wr_reg(ADDR_BREAK_STATUS, 8'h00);
    check("break_stop_wait_flag", 8'h00, {7'h00, bsw});
    pulse(7'h01, 4'h1);
    pulse(7'h04, 4'h0);
    check("break_stop_wait_flag", 8'h00, {7'h00, bsw});
    rd_reg(ADDR_RESET_STATUS, 8'h20, "reset_status");
    pulse(7'h01, 4'h1);
    @(posedge clk_sys) brk <= 1'b1;
    wr_reg(ADDR_BREAK_STATUS, 8'h00);
    check("break_stop_wait_flag", 8'h01, {7'h00, bsw});
    pulse(7'h02, 4'h0);
    rd_reg(ADDR_RESET_STATUS, 8'h40, "reset_status in break");
    rd_reg(ADDR_RESET_STATUS, 8'h40, "reset_status in break");
    @(posedge clk_sys) brk <= 1'b0;
    rd_reg(ADDR_RESET_STATUS, 8'h40, "reset_status after break");
    rd_reg(ADDR_RESET_STATUS, 8'h00, "reset_status after break");
    wr_reg(ADDR_BREAK_FLAG_CONTROL, 8'h80);
    check("break_clear_enable", 8'h01, {7'h00, bce});
    rd_reg(ADDR_BREAK_FLAG_CONTROL, 8'h80, "break_flag_control");
    pulse(7'h01, 4'h1);
    @(posedge clk_sys) brk <= 1'b1;
    wr_reg(ADDR_BREAK_STATUS, 8'h00);
    rd_reg(ADDR_BLOCK_STATE, 8'h03, "block_state");
    @(posedge clk_sys) brk <= 1'b0;
    rd_reg(ADDR_BREAK_STATUS, 8'h00, "break_status after break");
    wr_reg(ADDR_IRQ_STATUS, 8'h03);
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    rd_reg(ADDR_IRQ_MASK, 8'h01, "irq mask");
    pulse(7'h01, 4'h1);
    check("irq", 8'h01, {7'h00, irq});
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    @(posedge clk_sys);
    #1;
    check("irq", 8'h00, {7'h00, irq});
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    pulse(7'h01, 4'h1);
    check("irq", 8'h00, {7'h00, irq});
    rd_reg(ADDR_IRQ_STATUS, 8'h01, "irq status");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd_reg(ADDR_RESET_STATUS, 8'h80, "reset_status second reset");
    check("break_stop_wait_flag", 8'h00, {7'h00, bsw});
    check("break_clear_enable", 8'h00, {7'h00, bce});
    close_out();
  end
endmodule
